// file: common/dmu_pkg.sv
// Purpose: shared constants and types of the data move instruction unit
// Assumes: 8-bit core, one instruction handed over at a time, fully fetched
// Notes: opcode, address and field constants live here only
package dmu_pkg;

    // ************************************************************
    // opcodes (full bytes or high bits of patterns)
    // ************************************************************
    localparam logic [7:0] OP_ACC_TO_DIR = 8'hF5;
    localparam logic [4:0] OP_BANK_TO_DIR = 5'h11;
    localparam logic [7:0] OP_DIR_TO_DIR = 8'h85;
    localparam logic [6:0] OP_IND_TO_DIR = 7'h43;
    localparam logic [7:0] OP_IMM_TO_DIR = 8'h75;
    localparam logic [6:0] OP_DIR_TO_IND = 7'h53;
    localparam logic [6:0] OP_IMM_TO_IND = 7'h3B;
    localparam logic [6:0] OP_ACC_TO_IND = 7'h7B;
    localparam logic [7:0] OP_BIT_TO_CY = 8'hA3;
    localparam logic [7:0] OP_CY_TO_BIT = 8'h92;
    localparam logic [7:0] OP_PTR_LOAD = 8'h90;
    localparam logic [7:0] OP_CODE_PTR = 8'h93;
    localparam logic [7:0] OP_CODE_PROG = 8'h83;
    localparam logic [6:0] OP_XRD_REG = 7'h71;
    localparam logic [6:0] OP_XWR_REG = 7'h79;
    localparam logic [7:0] OP_XRD_PTR = 8'hE0;
    localparam logic [7:0] OP_XWR_PTR = 8'hF0;

    // ************************************************************
    // special function addresses, fields and reset values
    // ************************************************************
    localparam logic [7:0] SFR_BASE = 8'h80;
    localparam logic [7:0] SFR_ACC = 8'hE0;
    localparam logic [7:0] SFR_STATUS = 8'hD0;
    localparam logic [7:0] SFR_PTR_LOW = 8'h82;
    localparam logic [7:0] SFR_PTR_HIGH = 8'h83;
    localparam logic [7:0] SFR_HIGH_PORT = 8'hA0;
    localparam logic [7:0] BIT_RAM_BASE = 8'h20;
    localparam int STATUS_CY = 7;
    localparam int STATUS_BANK_LO = 3;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] HIGH_PORT_RST = 8'hFF;
    localparam logic [7:0] LOW_PORT_RST = 8'hFF;
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic [1:0] STROBE_CYCLES = 2'h3;
    localparam int RAM_DEPTH = 256;

    typedef enum logic [4:0] {
        K_NONE, K_ACC_DIR, K_BANK_DIR, K_DIR_DIR, K_IND_DIR, K_IMM_DIR,
        K_DIR_IND, K_IMM_IND, K_ACC_IND, K_BIT_CY, K_CY_BIT, K_PTR_LOAD,
        K_CODE_PTR, K_CODE_PROG, K_XRD_REG, K_XWR_REG, K_XRD_PTR, K_XWR_PTR
    } dmu_kind_type;

    typedef struct packed {
        dmu_kind_type kind;
        logic [2:0] sel;
        logic [1:0] nbytes;
        logic twoCycle;
    } dmu_dec_type;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] arg1;
        logic [7:0] arg2;
    } dmu_instr_type;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_WAIT = 5'h02,
        ST_CODE = 5'h04,
        ST_XADR = 5'h08,
        ST_XSTB = 5'h10
    } dmu_state_type;

endpackage

// file: tb/data_move_instruction_unit_tb.sv
// Purpose: self-checking bench of the data move unit
// Assumes: one instruction presented at a time
// Notes: model state kept in mAcc, mDp and mCy
`timescale 1ns/1ps
module data_move_instruction_unit_tb;
    import dmu_pkg::*;
    // ************************************************************
    // bench
    // ************************************************************
    logic clk = 0, reset = 1, instrValid = 0, mCy = 0;
    dmu_instr_type instr = '0;
    logic [15:0] instrAddr = 16'h0000, mDp = 16'h0000, nextInstrAddr, dataPointerOut, codeAddr;
    logic [7:0] codeData, lowPortIn, accOut, lowPortOut, highPortOut, k, mAcc = 8'h00;
    logic busy, done, carryOut, codeReq, lowPortOe_n, addrLatch, readStrobe_n, writeStrobe_n;
    int errors = 0, samples_checked = 0, seed = 45343;
    always #20 clk = ~clk;
    assign codeData = codeAddr[7:0] ^ codeAddr[15:8];
    dmu_core DUT (.clk(clk), .reset(reset), .instrValid(instrValid), .instr(instr),
        .instrAddr(instrAddr), .codeData(codeData), .lowPortIn(lowPortIn), .busy(busy),
        .done(done), .nextInstrAddr(nextInstrAddr), .accOut(accOut), .carryOut(carryOut),
        .dataPointerOut(dataPointerOut), .codeAddr(codeAddr), .codeReq(codeReq),
        .lowPortOut(lowPortOut), .lowPortOe_n(lowPortOe_n), .highPortOut(highPortOut),
        .addrLatch(addrLatch), .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n));
    dmu_ext_mem u_mem (.clk(clk), .lowPortOut(lowPortOut), .highPortOut(highPortOut),
        .addrLatch(addrLatch), .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n),
        .lowPortIn(lowPortIn));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        if (errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // present one instruction, count cycles to done, compare model state
    task automatic run(input logic [7:0] op, a1, a2, input int cyc);
        int n;
        n = 1;
        // one idle edge first, so a stale done pulse is gone and valid is set once per step
        @(posedge clk);
        #1 instr = '{op, a1, a2};
        instrValid = 1'b1;
        @(posedge clk);
        #1 instrValid = 1'b0;
        while (done !== 1'b1 && n < 9) begin
            @(posedge clk);
            #1 n++;
        end
        if (done !== 1'b1) begin
            errors++;
            summarize();
        end
        check(16'(n), 16'(cyc));
        check(16'(busy), 16'h0000);
        check(accOut, mAcc);
        check(dataPointerOut, mDp);
        check(16'(carryOut), 16'(mCy));
    endtask
    initial begin
        repeat (16) @(posedge clk);
        #1 reset = 1'b0;
        k = 8'($random(seed));
        run(8'h75, 8'h30, k, 2);
        mAcc = k;
        run(8'h85, 8'h30, SFR_ACC, 2);
        run(8'hF5, 8'h31, 8'h00, 1);
        mAcc = 8'h00;
        run(8'h75, SFR_ACC, 8'h00, 2);
        mAcc = k;
        run(8'h85, 8'h31, SFR_ACC, 2);
        run(8'h75, SFR_STATUS, 8'h08, 2);
        run(8'h75, 8'h09, 8'h40, 2);
        run(8'h77, 8'h5A, 8'h00, 1);
        run(8'h87, 8'h32, 8'h00, 2);
        run(8'h89, 8'h33, 8'h00, 2);
        run(8'hA7, 8'h30, 8'h00, 2);
        mAcc = 8'h5A;
        run(8'h85, 8'h32, SFR_ACC, 2);
        mAcc = 8'h40;
        run(8'h85, 8'h33, SFR_ACC, 2);
        mAcc = k;
        run(8'h87, SFR_ACC, 8'h00, 2);
        run(8'h75, 8'h20, 8'hA5, 2);
        run(8'h75, 8'h21, 8'h00, 2);
        for (int b = 0; b < 8; b++) begin
            mCy = ((8'hA5 >> b) & 1) != 0;
            run(8'hA3, 8'(b), 8'h00, 1);
        end
        run(8'h92, 8'h09, 8'h00, 2);
        mAcc = 8'h02;
        run(8'h85, 8'h21, SFR_ACC, 2);
        mDp = 16'h12F0;
        run(8'h90, 8'h12, 8'hF0, 2);
        check(nextInstrAddr, 16'h0003);
        mAcc = 8'h20;
        run(8'h75, SFR_ACC, 8'h20, 2);
        mAcc = 8'h03;
        run(8'h93, 8'h00, 8'h00, 2);
        check(codeAddr, 16'h1310);
        instrAddr = 16'h40FF;
        mAcc = 8'h42;
        run(8'h83, 8'h00, 8'h00, 2);
        check(codeAddr, 16'h4103);
        check(nextInstrAddr, 16'h4100);
        run(8'hF0, 8'h00, 8'h00, 5);
        check(u_mem.lastAddr, mDp);
        check(highPortOut, HIGH_PORT_RST);
        mAcc = 8'h5A;
        run(8'h75, SFR_ACC, 8'h5A, 2);
        run(8'hF3, 8'h00, 8'h00, 5);
        check(u_mem.lastAddr, 16'hFF40);
        mAcc = 8'h00;
        run(8'h75, SFR_ACC, 8'h00, 2);
        mAcc = 8'h42;
        run(8'hE0, 8'h00, 8'h00, 5);
        check(highPortOut, HIGH_PORT_RST);
        mAcc = 8'h5A;
        run(8'hE3, 8'h00, 8'h00, 5);
        check(u_mem.lastAddr, 16'hFF40);
        summarize();
    end
endmodule

// file: tb/dmu_ext_mem.sv
// Purpose: external data memory on the multiplexed port
// Assumes: address latched on addrLatch
// Notes: a released bus shows the inverse of the last byte driven
`timescale 1ns/1ps
module dmu_ext_mem (
    input wire logic clk,
    input wire logic [7:0] lowPortOut,
    input wire logic [7:0] highPortOut,
    input wire logic addrLatch,
    input wire logic readStrobe_n,
    input wire logic writeStrobe_n,
    output logic [7:0] lowPortIn
);
    // ************************************************************
    // storage and bus
    // ************************************************************
    logic [7:0] mem [0:65535];
    logic [15:0] lastAddr = 16'h0000;
    logic [7:0] last = 8'h00;
    always @(posedge clk) begin
        if (addrLatch) lastAddr <= {highPortOut, lowPortOut};
        if (!writeStrobe_n) mem[lastAddr] <= lowPortOut;
        if (!readStrobe_n) last <= mem[lastAddr];
    end
    // data only while the read strobe is low
    assign lowPortIn = readStrobe_n ? ~last : mem[lastAddr];
endmodule

// file: verilog/dmu_core.sv
// Purpose: executes the data move instruction group of an 8-bit core
// Assumes: whole instruction bytes arrive with instrValid while not busy
// Notes: owns accumulator, status, data pointer, high port latch and RAM
`timescale 1ns/1ps
module dmu_core #(
    parameter logic [1:0] STROBE_LEN = dmu_pkg::STROBE_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic instrValid,
    input dmu_pkg::dmu_instr_type instr,
    input wire logic [15:0] instrAddr,
    input wire logic [7:0] codeData,
    input wire logic [7:0] lowPortIn,
    output logic busy,
    output logic done,
    output logic [15:0] nextInstrAddr,
    output logic [7:0] accOut,
    output logic carryOut,
    output logic [15:0] dataPointerOut,
    output logic [15:0] codeAddr,
    output logic codeReq,
    output logic [7:0] lowPortOut,
    output logic lowPortOe_n,
    output logic [7:0] highPortOut,
    output logic addrLatch,
    output logic readStrobe_n,
    output logic writeStrobe_n
);
    import dmu_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    dmu_dec_type dec;
    dmu_state_type state_ff, nxt_state;
    logic [7:0] acc_ff, nxt_acc, status_ff, nxt_status, hiSfr_ff, nxt_hiSfr;
    logic [7:0] ptrHigh_ff, nxt_ptrHigh, ptrLow_ff, nxt_ptrLow;
    logic [1:0] cnt_ff, nxt_cnt;
    logic done_ff, nxt_done, busy_ff, nxt_busy, codeReq_ff, nxt_codeReq;
    logic xRead_ff, nxt_xRead, ale_ff, nxt_ale, rdN_ff, nxt_rdN, wrN_ff, nxt_wrN;
    logic oeN_ff, nxt_oeN;
    logic [7:0] lowOut_ff, nxt_lowOut, hiOut_ff, nxt_hiOut;
    logic [15:0] nextAddr_ff, nxt_nextAddr, codeAddr_ff, nxt_codeAddr;
    logic [7:0] inSync1_ff, inSync2_ff;
    logic [7:0] ram [RAM_DEPTH];
    logic ramWe;
    logic [7:0] ramWa, ramWd;
    logic dirWe;
    logic [7:0] dirWa, dirWd, ptrVal, bitByte;
    logic accept;

    dmu_decoder u_dec (
        .opcode(instr.opcode),
        .dec(dec)
    );

    assign accept = instrValid && (state_ff == ST_IDLE);

    // ************************************************************
    // address helpers
    // ************************************************************
    function automatic logic [7:0] bankAddr(input logic [7:0] st, input logic [2:0] r);
        bankAddr = {3'h0, st[STATUS_BANK_LO +: 2], r};
    endfunction

    function automatic logic [7:0] readDirect(input logic [7:0] a);
        readDirect = 8'h00;
        if (a < SFR_BASE) begin
            readDirect = ram[a];
        end else begin
            case (a)
                SFR_ACC: readDirect = acc_ff;
                SFR_STATUS: readDirect = status_ff;
                SFR_PTR_LOW: readDirect = ptrLow_ff;
                SFR_PTR_HIGH: readDirect = ptrHigh_ff;
                SFR_HIGH_PORT: readDirect = hiSfr_ff;
                default: readDirect = 8'h00;
            endcase
        end
    endfunction

    // bits below the special area sit in the bit-addressable RAM bytes
    function automatic logic [7:0] bitHome(input logic [7:0] b);
        if (b < SFR_BASE) begin
            bitHome = 8'(BIT_RAM_BASE + {4'h0, b[6:3]});
        end else begin
            bitHome = {b[7:3], 3'h0};
        end
    endfunction

    assign ptrVal = ram[bankAddr(status_ff, {2'h0, dec.sel[0]})];
    // a continuous assign would miss changes to the RAM and SFRs read inside the function
    always_comb begin
        bitByte = readDirect(bitHome(instr.arg1));
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_acc = acc_ff;
        nxt_status = status_ff;
        nxt_hiSfr = hiSfr_ff;
        nxt_ptrHigh = ptrHigh_ff;
        nxt_ptrLow = ptrLow_ff;
        nxt_cnt = cnt_ff;
        nxt_done = 1'b0;
        nxt_busy = busy_ff;
        nxt_codeReq = 1'b0;
        nxt_codeAddr = codeAddr_ff;
        nxt_nextAddr = nextAddr_ff;
        nxt_xRead = xRead_ff;
        nxt_ale = 1'b0;
        nxt_rdN = 1'b1;
        nxt_wrN = 1'b1;
        nxt_oeN = oeN_ff;
        nxt_lowOut = lowOut_ff;
        nxt_hiOut = hiOut_ff;
        ramWe = 1'b0;
        ramWa = 8'h00;
        ramWd = 8'h00;
        dirWe = 1'b0;
        dirWa = 8'h00;
        dirWd = 8'h00;
        case (state_ff)
            ST_IDLE: begin
                if (instrValid) begin
                    nxt_nextAddr = 16'(instrAddr + {14'h0000, dec.nbytes});
                    nxt_done = !dec.twoCycle;
                    nxt_state = dec.twoCycle ? ST_WAIT : ST_IDLE;
                    nxt_busy = dec.twoCycle;
                    case (dec.kind)
                        K_ACC_DIR: begin
                            dirWe = 1'b1;
                            dirWa = instr.arg1;
                            dirWd = acc_ff;
                        end
                        K_BANK_DIR: begin
                            dirWe = 1'b1;
                            dirWa = instr.arg1;
                            dirWd = ram[bankAddr(status_ff, dec.sel)];
                        end
                        K_DIR_DIR: begin
                            dirWe = 1'b1;
                            dirWa = instr.arg2;
                            dirWd = readDirect(instr.arg1);
                        end
                        K_IND_DIR: begin
                            dirWe = 1'b1;
                            dirWa = instr.arg1;
                            dirWd = ram[ptrVal];
                        end
                        K_IMM_DIR: begin
                            dirWe = 1'b1;
                            dirWa = instr.arg1;
                            dirWd = instr.arg2;
                        end
                        K_DIR_IND: begin
                            ramWe = 1'b1;
                            ramWa = ptrVal;
                            ramWd = readDirect(instr.arg1);
                        end
                        K_IMM_IND: begin
                            ramWe = 1'b1;
                            ramWa = ptrVal;
                            ramWd = instr.arg1;
                        end
                        K_ACC_IND: begin
                            ramWe = 1'b1;
                            ramWa = ptrVal;
                            ramWd = acc_ff;
                        end
                        K_BIT_CY: begin
                            nxt_status[STATUS_CY] = bitByte[instr.arg1[2:0]];
                        end
                        K_CY_BIT: begin
                            dirWe = 1'b1;
                            dirWa = bitHome(instr.arg1);
                            dirWd = bitByte;
                            dirWd[instr.arg1[2:0]] = status_ff[STATUS_CY];
                        end
                        K_PTR_LOAD: begin
                            nxt_ptrHigh = instr.arg1;
                            nxt_ptrLow = instr.arg2;
                        end
                        K_CODE_PTR: begin
                            nxt_codeAddr = 16'({ptrHigh_ff, ptrLow_ff} + {8'h00, acc_ff});
                            nxt_codeReq = 1'b1;
                            nxt_state = ST_CODE;
                        end
                        K_CODE_PROG: begin
                            nxt_codeAddr = 16'(instrAddr + 16'h0001 + {8'h00, acc_ff});
                            nxt_codeReq = 1'b1;
                            nxt_state = ST_CODE;
                        end
                        K_XRD_REG, K_XWR_REG, K_XRD_PTR, K_XWR_PTR: begin
                            nxt_done = 1'b0;
                            nxt_busy = 1'b1;
                            nxt_state = ST_XADR;
                            nxt_ale = 1'b1;
                            nxt_oeN = 1'b0;
                            nxt_xRead = (dec.kind == K_XRD_REG) || (dec.kind == K_XRD_PTR);
                            if (dec.kind == K_XRD_PTR || dec.kind == K_XWR_PTR) begin
                                nxt_lowOut = ptrLow_ff;
                                nxt_hiOut = ptrHigh_ff;
                            end else begin
                                nxt_lowOut = ptrVal;
                            end
                        end
                        default: begin
                            nxt_done = 1'b1;
                        end
                    endcase
                end
            end
            ST_WAIT: begin
                nxt_done = 1'b1;
                nxt_busy = 1'b0;
                nxt_state = ST_IDLE;
            end
            ST_CODE: begin
                nxt_acc = codeData;
                nxt_done = 1'b1;
                nxt_busy = 1'b0;
                nxt_state = ST_IDLE;
            end
            ST_XADR: begin
                nxt_state = ST_XSTB;
                nxt_cnt = STROBE_LEN - 2'h1;
                nxt_rdN = !xRead_ff;
                nxt_wrN = xRead_ff;
                nxt_oeN = xRead_ff;
                nxt_lowOut = xRead_ff ? lowOut_ff : acc_ff;
            end
            ST_XSTB: begin
                if (cnt_ff == 2'h0) begin
                    if (xRead_ff) begin
                        nxt_acc = inSync2_ff;
                    end
                    nxt_oeN = 1'b1;
                    nxt_lowOut = LOW_PORT_RST;
                    nxt_hiOut = hiSfr_ff;
                    nxt_done = 1'b1;
                    nxt_busy = 1'b0;
                    nxt_state = ST_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - 2'h1;
                    nxt_rdN = rdN_ff;
                    nxt_wrN = wrN_ff;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_busy = 1'b0;
            end
        endcase
        if (dirWe) begin
            if (dirWa < SFR_BASE) begin
                ramWe = 1'b1;
                ramWa = dirWa;
                ramWd = dirWd;
            end else begin
                case (dirWa)
                    SFR_ACC: nxt_acc = dirWd;
                    SFR_STATUS: nxt_status = dirWd;
                    SFR_PTR_LOW: nxt_ptrLow = dirWd;
                    SFR_PTR_HIGH: nxt_ptrHigh = dirWd;
                    SFR_HIGH_PORT: nxt_hiSfr = dirWd;
                    default: nxt_acc = acc_ff;
                endcase
            end
        end
        // port follows its latch whenever no external cycle owns it
        if (nxt_state == ST_IDLE || nxt_state == ST_WAIT || nxt_state == ST_CODE) begin
            nxt_hiOut = nxt_hiSfr;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= ST_IDLE;
            acc_ff <= ACC_RST;
            status_ff <= STATUS_RST;
            hiSfr_ff <= HIGH_PORT_RST;
            ptrHigh_ff <= PTR_RST[15:8];
            ptrLow_ff <= PTR_RST[7:0];
            cnt_ff <= 2'h0;
            done_ff <= 1'b0;
            busy_ff <= 1'b0;
            codeReq_ff <= 1'b0;
            codeAddr_ff <= 16'h0000;
            nextAddr_ff <= 16'h0000;
            xRead_ff <= 1'b0;
            ale_ff <= 1'b0;
            rdN_ff <= 1'b1;
            wrN_ff <= 1'b1;
            oeN_ff <= 1'b1;
            lowOut_ff <= LOW_PORT_RST;
            hiOut_ff <= HIGH_PORT_RST;
        end else begin
            state_ff <= nxt_state;
            acc_ff <= nxt_acc;
            status_ff <= nxt_status;
            hiSfr_ff <= nxt_hiSfr;
            ptrHigh_ff <= nxt_ptrHigh;
            ptrLow_ff <= nxt_ptrLow;
            cnt_ff <= nxt_cnt;
            done_ff <= nxt_done;
            busy_ff <= nxt_busy;
            codeReq_ff <= nxt_codeReq;
            codeAddr_ff <= nxt_codeAddr;
            nextAddr_ff <= nxt_nextAddr;
            xRead_ff <= nxt_xRead;
            ale_ff <= nxt_ale;
            rdN_ff <= nxt_rdN;
            wrN_ff <= nxt_wrN;
            oeN_ff <= nxt_oeN;
            lowOut_ff <= nxt_lowOut;
            hiOut_ff <= nxt_hiOut;
        end
    end

    // memory contents are not reset, as in a real scratch RAM
    always_ff @(posedge clk) begin
        if (ramWe) begin
            ram[ramWa] <= ramWd;
        end
    end

    // pin data crosses in from outside the clock domain
    always_ff @(posedge clk) begin
        inSync1_ff <= lowPortIn;
        inSync2_ff <= inSync1_ff;
    end

    assign busy = busy_ff;
    assign done = done_ff;
    assign nextInstrAddr = nextAddr_ff;
    assign accOut = acc_ff;
    assign carryOut = status_ff[STATUS_CY];
    assign dataPointerOut = {ptrHigh_ff, ptrLow_ff};
    assign codeAddr = codeAddr_ff;
    assign codeReq = codeReq_ff;
    assign lowPortOut = lowOut_ff;
    assign lowPortOe_n = oeN_ff;
    assign highPortOut = hiOut_ff;
    assign addrLatch = ale_ff;
    assign readStrobe_n = rdN_ff;
    assign writeStrobe_n = wrN_ff;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_ACC_DIR_ONE: assert property (accept && dec.kind == K_ACC_DIR |=> done && !busy)
        else $error("accumulator store not done in one cycle");
    AST_TWO_CYCLE: assert property (accept && dec.twoCycle |=> !done ##1 done)
        else $error("two-cycle move not done on second cycle");
    AST_IMM_IND: assert property (accept && dec.kind == K_IMM_IND
        |=> ram[$past(ptrVal)] == $past(instr.arg1) && done)
        else $error("immediate not stored at pointer address");
    AST_BIT_CY: assert property (accept && dec.kind == K_BIT_CY
        |=> carryOut == $past(bitByte[instr.arg1[2:0]]) && $stable(accOut))
        else $error("carry not loaded from bit");
    AST_PTR_LOAD: assert property (accept && dec.kind == K_PTR_LOAD
        |=> dataPointerOut == {$past(instr.arg1), $past(instr.arg2)})
        else $error("data pointer load order wrong");
    AST_CODE_PTR: assert property (accept && dec.kind == K_CODE_PTR
        |=> codeReq && codeAddr == 16'($past(dataPointerOut) + {8'h00, $past(accOut)})
        ##1 done && accOut == $past(codeData))
        else $error("code read via pointer wrong");
    AST_CODE_PROG: assert property (accept && dec.kind == K_CODE_PROG
        |=> codeAddr == 16'($past(instrAddr) + 16'h0001 + {8'h00, $past(accOut)}))
        else $error("program based code address wrong");
    AST_ADDR_PHASE: assert property (addrLatch |-> !lowPortOe_n ##1
        (!addrLatch && (!readStrobe_n || !writeStrobe_n)))
        else $error("strobe does not follow address phase");
    AST_HIGH_PORT: assert property (accept && dec.kind == K_XRD_PTR
        |=> highPortOut == $past(dataPointerOut[15:8]) ##[4:5] highPortOut == hiSfr_ff)
        else $error("high port not driven then restored");
    AST_READ_RELEASE: assert property (!readStrobe_n |-> lowPortOe_n && writeStrobe_n)
        else $error("port driven during read strobe");

    COV_EXT_READ: cover property (accept && dec.kind == K_XRD_PTR ##[1:6] done);
    COV_EXT_WRITE: cover property (accept && dec.kind == K_XWR_REG ##[1:6] done);
    COV_CODE_PROG: cover property (accept && dec.kind == K_CODE_PROG ##2 done);

endmodule

// file: verilog/dmu_decoder.sv
// Purpose: opcode decoder of the data move instruction unit
// Assumes: opcode byte is stable while decoded
// Notes: purely combinational
`timescale 1ns/1ps
module dmu_decoder (
    input wire logic [7:0] opcode,
    output dmu_pkg::dmu_dec_type dec
);
    import dmu_pkg::*;

    always_comb begin
        dec = '{kind: K_NONE, sel: opcode[2:0], nbytes: 2'h1, twoCycle: 1'b0};
        if (opcode == OP_ACC_TO_DIR) begin
            dec.kind = K_ACC_DIR;
            dec.nbytes = 2'h2;
        end else if (opcode[7:3] == OP_BANK_TO_DIR) begin
            dec = '{kind: K_BANK_DIR, sel: opcode[2:0], nbytes: 2'h2, twoCycle: 1'b1};
        end else if (opcode == OP_DIR_TO_DIR) begin
            dec = '{kind: K_DIR_DIR, sel: opcode[2:0], nbytes: 2'h3, twoCycle: 1'b1};
        end else if (opcode[7:1] == OP_IND_TO_DIR) begin
            dec = '{kind: K_IND_DIR, sel: opcode[2:0], nbytes: 2'h2, twoCycle: 1'b1};
        end else if (opcode == OP_IMM_TO_DIR) begin
            dec = '{kind: K_IMM_DIR, sel: opcode[2:0], nbytes: 2'h3, twoCycle: 1'b1};
        end else if (opcode[7:1] == OP_DIR_TO_IND) begin
            dec = '{kind: K_DIR_IND, sel: opcode[2:0], nbytes: 2'h2, twoCycle: 1'b1};
        end else if (opcode[7:1] == OP_IMM_TO_IND) begin
            dec.kind = K_IMM_IND;
            dec.nbytes = 2'h2;
        end else if (opcode[7:1] == OP_ACC_TO_IND) begin
            dec.kind = K_ACC_IND;
        end else if (opcode == OP_BIT_TO_CY) begin
            dec.kind = K_BIT_CY;
            dec.nbytes = 2'h2;
        end else if (opcode == OP_CY_TO_BIT) begin
            dec = '{kind: K_CY_BIT, sel: opcode[2:0], nbytes: 2'h2, twoCycle: 1'b1};
        end else if (opcode == OP_PTR_LOAD) begin
            dec = '{kind: K_PTR_LOAD, sel: opcode[2:0], nbytes: 2'h3, twoCycle: 1'b1};
        end else if (opcode == OP_CODE_PTR) begin
            dec = '{kind: K_CODE_PTR, sel: opcode[2:0], nbytes: 2'h1, twoCycle: 1'b1};
        end else if (opcode == OP_CODE_PROG) begin
            dec = '{kind: K_CODE_PROG, sel: opcode[2:0], nbytes: 2'h1, twoCycle: 1'b1};
        end else if (opcode[7:1] == OP_XRD_REG) begin
            dec.kind = K_XRD_REG;
        end else if (opcode[7:1] == OP_XWR_REG) begin
            dec.kind = K_XWR_REG;
        end else if (opcode == OP_XRD_PTR) begin
            dec.kind = K_XRD_PTR;
        end else if (opcode == OP_XWR_PTR) begin
            dec.kind = K_XWR_PTR;
        end
    end

endmodule
